// file: design/bms_strap_cap.sv
// Strap and security capture for boot mode select.
// Assumes straps and security level are stable across the reset release.
`include "bms_consts.svh"
`default_nettype none

module bms_strap_cap
    import bms_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic flash_secure,
    input wire logic external_boot_strap,
    input wire logic wide_address_strap,
    bms_cfg_if.cap cfg
);
    bms_phase_t phase_r;

    // ----------------------------------------
    // Capture
    // ----------------------------------------
    // Async reset loads constants only; straps are taken on the first edge after release
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            phase_r <= BMS_CAP_WAIT;
            cfg.loaded <= 1'b0;
            cfg.mb <= 1'b0;
            cfg.ma <= 1'b0;
            cfg.wide <= 1'b0;
        end
        else if (phase_r == BMS_CAP_WAIT)
        begin
            phase_r <= BMS_CAP_DONE;
            cfg.loaded <= 1'b1;
            cfg.mb <= ~flash_secure;
            cfg.ma <= external_boot_strap & ~flash_secure;
            cfg.wide <= wide_address_strap;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    cap_hold_a: assert property (@(posedge clk) disable iff (rst)
        cfg.loaded |=> $stable({cfg.mb, cfg.ma, cfg.wide}) && cfg.loaded)
        else $error("mode bits moved after capture");
    secure_veto_a: assert property (@(posedge clk) disable iff (rst)
        cfg.ma |-> cfg.mb)
        else $error("external boot taken while secured");
    cap_once_a: assert property (@(posedge clk) disable iff (rst)
        $rose(cfg.loaded) |-> cfg.mb == !$past(flash_secure))
        else $error("security bit not taken from flash state");
endmodule

`default_nettype wire

// file: design/bms_top.sv
// Boot mode select core: operating mode register, effective mode outputs.
// Assumes a plain register port master and straps held through reset release.
`include "bms_consts.svh"
`default_nettype none

// Summary of operation
// - At reset the security bit is taken from flash security and the map bit from the boot pin, forced to zero when secured.
// - After reset a software write to the map bit changes the program memory map, unless secured at reset.
// - A software write to the security bit changes no operating behaviour.
// - With both bits zero the part boots inside, drives 16 lines, is secured, no debug.
// - A secured part asked to boot outside falls back to the all-zero mode.
// - Unsecured with the boot pin low the part boots inside with 16 address lines.
// - Unsecured with the boot pin high the part boots outside, width set by the wide strap.
// - The security bit is taken only at reset and ignores later flash changes.
// - Map bit zero picks the inside map, one the outside map, unless secured at reset.
// - A high wide strap at reset adds four address lines for 20 in all when the part boots outside.
module bms_top
    import bms_pkg::*;
#(
    parameter int EXTRA_LINES = `BMS_EXTRA_LINES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic flash_secure,
    input wire logic external_boot_strap,
    input wire logic wide_address_strap,
    input wire bms_pkg::bms_addr_t addr,
    input wire bms_pkg::bms_data_t wdata,
    input wire logic wr,
    input wire logic rd,
    output var bms_pkg::bms_data_t rdata,
    output var logic boot_external,
    output var logic map_external,
    output var logic ext_pspace_allowed,
    output var logic debug_enable,
    output var bms_pkg::bms_lines_t addr_lines
);
    import bms_pkg::*;

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    // Line count field is five bits wide
    generate
        if (EXTRA_LINES < 0 || EXTRA_LINES > 15)
        begin : g_bad
            $error("EXTRA_LINES out of range");
        end
    endgenerate

    localparam bms_lines_t LINES_WIDE = `BMS_LINES_NARROW + bms_lines_t'(EXTRA_LINES);
    localparam logic [1:0] OMR_RST_V = `BMS_OMR_RST;

    bms_cfg_if cfg ();

    bms_strap_cap u_cap (
        .clk(clk),
        .rst(rst),
        .flash_secure(flash_secure),
        .external_boot_strap(external_boot_strap),
        .wide_address_strap(wide_address_strap),
        .cfg(cfg.cap)
    );

    function automatic logic hit(input bms_addr_t a, input bms_addr_t ofs);
        hit = (a == ofs);
    endfunction

    logic loaded_q_r;
    logic ma_r;
    logic mb_r;
    logic load_evt;

    assign load_evt = cfg.loaded & ~loaded_q_r;

    // ----------------------------------------
    // Operating mode register
    // ----------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            loaded_q_r <= 1'b0;
        end
        else
        begin
            loaded_q_r <= cfg.loaded;
        end
    end

    // Capture wins over a same-cycle write; a write cannot land that early anyway
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ma_r <= OMR_RST_V[`BMS_MA_BIT];
            mb_r <= OMR_RST_V[`BMS_MB_BIT];
        end
        else if (load_evt)
        begin
            ma_r <= cfg.ma;
            mb_r <= cfg.mb;
        end
        else if (wr && hit(addr, `BMS_OMR_OFS))
        begin
            ma_r <= wdata[`BMS_MA_BIT];
            mb_r <= wdata[`BMS_MB_BIT];
        end
    end

    // ----------------------------------------
    // Effective mode outputs
    // ----------------------------------------
    // Behaviour follows the captured security bit, never the writable copy
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            map_external <= 1'b0;
            boot_external <= 1'b0;
            ext_pspace_allowed <= 1'b0;
            debug_enable <= 1'b0;
            addr_lines <= `BMS_LINES_NARROW;
        end
        else
        begin
            map_external <= ma_r & cfg.mb;
            boot_external <= cfg.ma;
            ext_pspace_allowed <= cfg.mb;
            debug_enable <= cfg.mb;
            addr_lines <= (cfg.ma && cfg.wide) ? LINES_WIDE : `BMS_LINES_NARROW;
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    bms_data_t stat;

    always_comb
    begin
        stat = '0;
        stat[`BMS_ST_BOOT_EXT] = boot_external;
        stat[`BMS_ST_MAP_EXT] = map_external;
        stat[`BMS_ST_PSPACE_OK] = ext_pspace_allowed;
        stat[`BMS_ST_DEBUG_EN] = debug_enable;
        stat[`BMS_ST_LOADED] = loaded_q_r;
        stat[`BMS_ST_LINES_MSB:`BMS_ST_LINES_LSB] = addr_lines;
    end

    // Unmapped reads and idle cycles return zero
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata <= 16'h0000;
        end
        else if (rd && hit(addr, `BMS_OMR_OFS))
        begin
            rdata <= {14'h0000, mb_r, ma_r};
        end
        else if (rd && hit(addr, `BMS_STAT_OFS))
        begin
            rdata <= stat;
        end
        else
        begin
            rdata <= 16'h0000;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    map_write_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && wr && hit(addr, `BMS_OMR_OFS) && cfg.mb
        |-> ##2 map_external == $past(wdata[`BMS_MA_BIT], 2))
        else $error("map bit write did not reach the map");
    map_locked_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && !cfg.mb |=> !map_external)
        else $error("map moved while secured at reset");
    mb_inert_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && wr && hit(addr, `BMS_OMR_OFS)
        |-> ##2 $stable(debug_enable) && $stable(boot_external)
            && $stable(ext_pspace_allowed) && $stable(addr_lines))
        else $error("mode register write changed behaviour");
    zero_mode_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && !cfg.mb |=> !boot_external && !debug_enable
            && !ext_pspace_allowed && addr_lines == `BMS_LINES_NARROW)
        else $error("secured mode not fully applied");
    narrow_inside_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && cfg.mb && !cfg.ma
        |=> !boot_external && addr_lines == `BMS_LINES_NARROW)
        else $error("inside boot not on 16 lines");
    wide_outside_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && cfg.ma && cfg.wide |=> boot_external && addr_lines == LINES_WIDE)
        else $error("wide strap did not widen the bus");
    read_omr_a: assert property (@(posedge clk) disable iff (rst)
        rd && hit(addr, `BMS_OMR_OFS) && !load_evt && !wr
        |=> rdata == {14'h0000, $past(mb_r), $past(ma_r)})
        else $error("mode register readback wrong");
    load_copy_a: assert property (@(posedge clk) disable iff (rst)
        load_evt |=> ma_r == cfg.ma && mb_r == cfg.mb)
        else $error("captured bits not loaded");
    boot_outside_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && cfg.ma |=> boot_external && ext_pspace_allowed && debug_enable)
        else $error("outside boot not applied");
    narrow_outside_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && cfg.ma && !cfg.wide |=> addr_lines == `BMS_LINES_NARROW)
        else $error("outside boot widened without the strap");
    mb_kept_a: assert property (@(posedge clk) disable iff (rst)
        loaded_q_r && wr && hit(addr, `BMS_OMR_OFS) |=> mb_r == $past(wdata[`BMS_MB_BIT]))
        else $error("security bit write not stored");

    cov_ext_wide_c: cover property (@(posedge clk) disable iff (rst)
        boot_external && addr_lines == LINES_WIDE);
    cov_secured_c: cover property (@(posedge clk) disable iff (rst)
        loaded_q_r && !cfg.mb);
    cov_map_flip_c: cover property (@(posedge clk) disable iff (rst)
        $fell(map_external));
    cov_inside_open_c: cover property (@(posedge clk) disable iff (rst)
        loaded_q_r && cfg.mb && !cfg.ma);
    cov_mb_write_c: cover property (@(posedge clk) disable iff (rst)
        loaded_q_r && wr && hit(addr, `BMS_OMR_OFS) && wdata[`BMS_MB_BIT] != mb_r);
endmodule

`default_nettype wire

// file: include/bms_cfg_if.sv
// Carrier of the captured mode bits from strap capture to the core.
// Assumes both ends share one clock.
`default_nettype none

interface bms_cfg_if;
    logic loaded;
    logic mb;
    logic ma;
    logic wide;
    modport cap (output loaded, output mb, output ma, output wide);
    modport core (input loaded, input mb, input ma, input wide);
endinterface

`default_nettype wire

// file: include/bms_consts.svh
// Offsets, field positions, reset values and line counts for boot mode select.
// Assumes inclusion by bare name from files that need these figures.
`ifndef BMS_CONSTS_SVH
`define BMS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BMS_OMR_OFS 4'h0
`define BMS_STAT_OFS 4'h1

// ----------------------------------------
// Operating mode register fields
// ----------------------------------------
`define BMS_MA_BIT 0
`define BMS_MB_BIT 1
`define BMS_OMR_RST 2'h0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define BMS_ST_BOOT_EXT 0
`define BMS_ST_MAP_EXT 1
`define BMS_ST_PSPACE_OK 2
`define BMS_ST_DEBUG_EN 3
`define BMS_ST_LOADED 4
`define BMS_ST_LINES_LSB 5
`define BMS_ST_LINES_MSB 9

// ----------------------------------------
// External address line counts
// ----------------------------------------
`define BMS_LINES_NARROW 5'h10
`define BMS_EXTRA_LINES 4

`endif

// file: include/bms_pkg.sv
// Types shared by the boot mode select modules.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package bms_pkg;
    typedef enum logic [0:0] {
        BMS_CAP_WAIT = 1'b0,
        BMS_CAP_DONE = 1'b1
    } bms_phase_t;
    typedef logic [3:0] bms_addr_t;
    typedef logic [15:0] bms_data_t;
    typedef logic [4:0] bms_lines_t;
endpackage

`default_nettype wire

// file: tb/bms_rst_model.sv
// Chip reset source and strap pins facing the boot mode select block.
// Assumes the bench pulses go for one cycle to ask for a fresh reset.
`default_nettype none

module bms_rst_model
(
    input wire logic clk,
    input wire logic go,
    input wire logic [2:0] cfg,
    output var logic rst,
    output var logic flash_secure,
    output var logic external_boot_strap,
    output var logic wide_address_strap
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 20;

    // ----------------------------------------
    // Reset pulse of 20 cycles
    // ----------------------------------------
    always @(posedge clk)
    begin
        if (go)
            cnt <= 20;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign rst = (cnt != 0);

    // Straps follow cfg; the bench keeps cfg still across release
    assign flash_secure = cfg[2];
    assign external_boot_strap = cfg[1];
    assign wide_address_strap = cfg[0];
endmodule

`default_nettype wire

// file: tb/boot_mode_select_tb.sv
// Self-checking bench for boot mode select: all strap cases, map bit writes.
// Assumes the reset model drives rst and the straps.
`include "bms_consts.svh"
`default_nettype none

module boot_mode_select_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import bms_pkg::*;
    localparam int EXTRA = 4;
    logic clk = 1'b0;
    logic go = 1'b0;
    logic [2:0] cfg = 3'h0;
    bms_addr_t addr = '0;
    bms_data_t wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic rst, fsec, xboot, wide, bext, mext, psp, dbg;
    bms_data_t rdata;
    bms_lines_t lines;
    int error_cnt = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    bms_rst_model part (.clk(clk), .go(go), .cfg(cfg), .rst(rst), .flash_secure(fsec),
        .external_boot_strap(xboot), .wide_address_strap(wide));
    bms_top #(.EXTRA_LINES(EXTRA)) dut (.clk(clk), .rst(rst), .flash_secure(fsec),
        .external_boot_strap(xboot), .wide_address_strap(wide), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .boot_external(bext),
        .map_external(mext), .ext_pspace_allowed(psp), .debug_enable(dbg),
        .addr_lines(lines));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    task stop_test;
        $display("Checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task wr_reg(input bms_addr_t a, input bms_data_t d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task rd_reg(input bms_addr_t a, output bms_data_t d);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task do_reset(input logic [2:0] c);
        int i;
        @(posedge clk);
        cfg <= c;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        #1 i = 0;
        while (rst !== 1'b0 && i < 100)
        begin
            @(posedge clk);
            i++;
        end
        if (i >= 100)
        begin
            error_cnt++;
            stop_test();
        end
        repeat (4) @(posedge clk);
        #1;
    endtask

    function automatic logic [15:0] outs();
        return {12'h000, bext, mext, psp, dbg};
    endfunction

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        logic mb, ma;
        bms_lines_t nl;
        bms_data_t d;
        for (int c = 0; c < 8; c++)
        begin
            do_reset(c[2:0]);
            mb = ~c[2];
            ma = c[1] & ~c[2];
            nl = (ma & c[0]) ? `BMS_LINES_NARROW + 5'(EXTRA) : `BMS_LINES_NARROW;
            check(outs(), {12'h000, ma, ma, mb, mb});
            check({11'h000, lines}, {11'h000, nl});
            rd_reg(`BMS_OMR_OFS, d);
            check(d, {14'h0000, mb, ma});
            rd_reg(`BMS_STAT_OFS, d);
            check(d, {6'h00, nl, 1'b1, mb, mb, ma, ma});
            // Map bit set, then cleared
            wr_reg(`BMS_OMR_OFS, {14'h0000, mb, 1'b1});
            repeat (2) @(posedge clk);
            #1 check({15'h0000, mext}, {15'h0000, mb});
            wr_reg(`BMS_OMR_OFS, {14'h0000, mb, 1'b0});
            repeat (2) @(posedge clk);
            #1 check({15'h0000, mext}, 16'h0000);
            // Security bit flipped by software: stored, no effect
            wr_reg(`BMS_OMR_OFS, {14'h0000, ~mb, 1'b0});
            repeat (2) @(posedge clk);
            #1 check(outs(), {12'h000, ma, 1'b0, mb, mb});
            rd_reg(`BMS_OMR_OFS, d);
            check(d, {14'h0000, ~mb, 1'b0});
            // Straps and security change after release: ignored
            @(posedge clk);
            cfg <= ~cfg;
            repeat (3) @(posedge clk);
            rd_reg(`BMS_STAT_OFS, d);
            check(d, {6'h00, nl, 1'b1, mb, mb, 1'b0, ma});
            check({11'h000, lines}, {11'h000, nl});
            $display("Strap case %0d done", c);
        end
        rd_reg(4'h5, d);
        check(d, 16'h0000);
        $display("Unmapped read done");
        stop_test();
    end
endmodule

`default_nettype wire
